// *** design/amcs_map.svh ***
/*
  register numbers, field widths, reset values and limits for the per-axis
  motion and chopper settings block.
  assumes: included by the package and the design module; no other use.
*/
`ifndef AMCS_MAP_SVH
`define AMCS_MAP_SVH

`define AMCS_REG_RAMP_MODE     8'h8a
`define AMCS_REG_USTEP_RES     8'h8c
`define AMCS_REG_SOFT_STOP     8'h95
`define AMCS_REG_SW_PWRDN      8'h96
`define AMCS_REG_ACC_EXP       8'h99
`define AMCS_REG_VEL_EXP       8'h9a
`define AMCS_REG_INTERP        8'ha0
`define AMCS_REG_DBL_STEP      8'ha1
`define AMCS_REG_BLANK         8'ha2
`define AMCS_REG_CHOP_SEL      8'ha3
`define AMCS_REG_FD_CMP_OFF    8'ha4
`define AMCS_REG_HEND_TFD      8'ha5
`define AMCS_REG_HSTRT_OFS     8'ha6

`define AMCS_MAX_RAMP_MODE     2'h2
`define AMCS_MAX_USTEP         4'h8
`define AMCS_MAX_EXP           4'hd
`define AMCS_MAX_HSTRT         4'h8
`define AMCS_USTEP_16          4'h4

`define AMCS_RST_RAMP_MODE     2'h0
`define AMCS_RST_USTEP         4'h8
`define AMCS_RST_EXP           4'h0
`define AMCS_RST_BLANK         2'h0
`define AMCS_RST_NIB           4'h0

`endif

// *** design/amcs_pkg.sv ***
/*
  types for the per-axis motion and chopper settings block.
  assumes: amcs_map.svh in the include path.
*/
`include "amcs_map.svh"

package amcs_pkg;

  typedef enum logic [1:0] {
    AMCS_RAMP_POSITION,
    AMCS_RAMP_SOFT,
    AMCS_RAMP_VELOCITY,
    AMCS_RAMP_RSVD
  } amcs_ramp_t;

  typedef enum logic [2:0] {
    AMCS_CMD_NONE,
    AMCS_CMD_ROTATE_RIGHT,
    AMCS_CMD_ROTATE_LEFT,
    AMCS_CMD_MOTOR_HALT,
    AMCS_CMD_MOVE_TO_TARGET
  } amcs_cmd_t;

  typedef enum logic {
    AMCS_CHOP_HYSTERESIS,
    AMCS_CHOP_CONST_OFF
  } amcs_chop_t;

  // parameter access from the host
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] num;
    logic [7:0] wdata;
  } amcs_req_t;

  typedef struct packed {
    logic       ack;
    logic       err;
    logic [7:0] rdata;
  } amcs_rsp_t;

  // settings presented to the ramp generator
  typedef struct packed {
    amcs_ramp_t ramp_mode;
    logic       linear_decel;
    logic       exp_decel;
    logic       run_continuous;
    logic       pos_tracking;
    logic [3:0] acc_exp;
    logic [3:0] vel_exp;
    logic       sw_stop_soft;
    logic       sw_stop_standby;
  } amcs_ramp_cfg_t;

  // settings presented to the step sequencer and chopper
  typedef struct packed {
    logic [3:0] ustep_res;
    logic [8:0] ustep_per_full;
    logic [8:0] sub_steps;
    logic [1:0] blank_sel;
    amcs_chop_t chop_mode;
    logic       fd_cmp_off;
    logic [3:0] hyst_end;
    logic [3:0] hyst_start;
    logic [3:0] fd_time;
    logic [3:0] sine_offset;
  } amcs_drv_cfg_t;

endpackage

// *** design/amcs_settings.sv ***
/*
  per-axis settings store for a stepper motion controller and chopper
  driver: parameter read/write by number, ramp mode tracking of motion
  commands, decoded configuration for the ramp generator and chopper,
  and the switch-stop action.
  assumes: host requests synchronous to clk_sys; motion commands arrive as
  one-cycle strobes; the ramp generator consumes ramp_cfg, stop_hard and stop_soft.
*/
// Summary of operation
// - motion commands rewrite ramp mode automatically
// - mode 0: position tracking, trapezoidal ramps
// - mode 2: continuous run, ramp at acceleration
// - mode 1: exponential speed decrease
// - resolution codes 0..8, full to 256
// - switch stop hard or soft per flag
// - switch stop keeps run or standby current
// - acceleration exponent 0..13, power-of-two scale
// - velocity exponent 0..13, power-of-two scale
// - interpolation at 16 microsteps gives 1/256
// - double step executes each microstep twice
// - blank time 0..3 masks comparator
// - chopper mode: 0 hysteresis, 1 constant-off
// - constant-off: comparator cannot end fast decay
// - 165 holds hysteresis end or decay time
// - 166 holds hysteresis start or sine offset
`include "amcs_map.svh"

module amcs_settings (
  input  wire logic                    clk_sys,
  input  wire logic                    sys_rst,
  input  wire amcs_pkg::amcs_req_t     host_req,
  output      amcs_pkg::amcs_rsp_t     host_rsp,
  input  wire amcs_pkg::amcs_cmd_t     motion_cmd,
  input  wire logic                    end_switch_hit,
  output      amcs_pkg::amcs_ramp_cfg_t ramp_cfg,
  output      amcs_pkg::amcs_drv_cfg_t  drv_cfg,
  output      logic                    stop_hard,
  output      logic                    stop_soft,
  output      logic                    standby_current
);
  import amcs_pkg::*;

  amcs_ramp_t ramp_mode_r;
  logic [3:0] ustep_r;
  logic       soft_stop_r;
  logic       sw_pwrdn_r;
  logic [3:0] acc_exp_r;
  logic [3:0] vel_exp_r;
  logic       interp_r;
  logic       dbl_step_r;
  logic [1:0] blank_r;
  amcs_chop_t chop_r;
  logic       fd_cmp_off_r;
  logic [3:0] hend_r;
  logic [3:0] hstrt_r;
  logic       switch_stopped_r;
  amcs_rsp_t  rsp_r;

  // range check per parameter number; also serves as the address decode
  function automatic logic [1:0] amcs_check(input logic [7:0] num, input logic [7:0] v);
    logic [1:0] res;
    res = 2'h0; // {mapped, in_range}
    case (num)
      `AMCS_REG_RAMP_MODE:  res = {1'b1, v <= {6'h00, `AMCS_MAX_RAMP_MODE}};
      `AMCS_REG_USTEP_RES:  res = {1'b1, v <= {4'h0, `AMCS_MAX_USTEP}};
      `AMCS_REG_SOFT_STOP,
      `AMCS_REG_SW_PWRDN,
      `AMCS_REG_INTERP,
      `AMCS_REG_DBL_STEP,
      `AMCS_REG_CHOP_SEL,
      `AMCS_REG_FD_CMP_OFF: res = {1'b1, v <= 8'h01};
      `AMCS_REG_ACC_EXP,
      `AMCS_REG_VEL_EXP:    res = {1'b1, v <= {4'h0, `AMCS_MAX_EXP}};
      `AMCS_REG_BLANK:      res = {1'b1, v <= 8'h03};
      `AMCS_REG_HEND_TFD:   res = {1'b1, v <= 8'h0f};
      `AMCS_REG_HSTRT_OFS:  res = {1'b1, v <= {4'h0, `AMCS_MAX_HSTRT}};
      default:              res = 2'h0;
    endcase
    return res;
  endfunction

  logic [1:0] wr_chk;
  logic [1:0] rd_chk;
  logic       wr_ok;
  assign wr_chk = amcs_check(host_req.num, host_req.wdata);
  // reads need only the mapped bit; the value argument is a don't-care
  assign rd_chk = amcs_check(host_req.num, 8'h00);
  assign wr_ok  = host_req.wr && wr_chk == 2'h3;

  function automatic logic wr_hit(input logic ok, input logic [7:0] num, input logic [7:0] reg_num);
    return ok && num == reg_num;
  endfunction

  // motion command wins over a same-cycle host write; it is the newer intent
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ramp_mode_r <= AMCS_RAMP_POSITION;
    end else begin
      case (motion_cmd)
        AMCS_CMD_ROTATE_RIGHT,
        AMCS_CMD_ROTATE_LEFT,
        AMCS_CMD_MOTOR_HALT:     ramp_mode_r <= AMCS_RAMP_VELOCITY;
        AMCS_CMD_MOVE_TO_TARGET: ramp_mode_r <= AMCS_RAMP_POSITION;
        default: begin
          if (wr_hit(wr_ok, host_req.num, `AMCS_REG_RAMP_MODE)) begin
            ramp_mode_r <= amcs_ramp_t'(host_req.wdata[1:0]);
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ustep_r      <= `AMCS_RST_USTEP;
      soft_stop_r  <= 1'b0;
      sw_pwrdn_r   <= 1'b0;
      acc_exp_r    <= `AMCS_RST_EXP;
      vel_exp_r    <= `AMCS_RST_EXP;
      interp_r     <= 1'b0;
      dbl_step_r   <= 1'b0;
      blank_r      <= `AMCS_RST_BLANK;
      chop_r       <= AMCS_CHOP_HYSTERESIS;
      fd_cmp_off_r <= 1'b0;
      hend_r       <= `AMCS_RST_NIB;
      hstrt_r      <= `AMCS_RST_NIB;
    end else if (wr_ok) begin
      case (host_req.num)
        `AMCS_REG_USTEP_RES:  ustep_r      <= host_req.wdata[3:0];
        `AMCS_REG_SOFT_STOP:  soft_stop_r  <= host_req.wdata[0];
        `AMCS_REG_SW_PWRDN:   sw_pwrdn_r   <= host_req.wdata[0];
        `AMCS_REG_ACC_EXP:    acc_exp_r    <= host_req.wdata[3:0];
        `AMCS_REG_VEL_EXP:    vel_exp_r    <= host_req.wdata[3:0];
        `AMCS_REG_INTERP:     interp_r     <= host_req.wdata[0];
        `AMCS_REG_DBL_STEP:   dbl_step_r   <= host_req.wdata[0];
        `AMCS_REG_BLANK:      blank_r      <= host_req.wdata[1:0];
        `AMCS_REG_CHOP_SEL:   chop_r       <= amcs_chop_t'(host_req.wdata[0]);
        `AMCS_REG_FD_CMP_OFF: fd_cmp_off_r <= host_req.wdata[0];
        `AMCS_REG_HEND_TFD:   hend_r       <= host_req.wdata[3:0];
        `AMCS_REG_HSTRT_OFS:  hstrt_r      <= host_req.wdata[3:0];
        default: ;
      endcase
    end
  end

  // read and write both answer next cycle; err flags unmapped or refused
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rsp_r <= '0;
    end else begin
      rsp_r.ack <= host_req.wr || host_req.rd;
      rsp_r.err <= (host_req.wr && !wr_ok) ||
                   (host_req.rd && !host_req.wr && !rd_chk[1]);
      if (host_req.rd && !host_req.wr) begin
        case (host_req.num)
          `AMCS_REG_RAMP_MODE:  rsp_r.rdata <= {6'h00, ramp_mode_r};
          `AMCS_REG_USTEP_RES:  rsp_r.rdata <= {4'h0, ustep_r};
          `AMCS_REG_SOFT_STOP:  rsp_r.rdata <= {7'h00, soft_stop_r};
          `AMCS_REG_SW_PWRDN:   rsp_r.rdata <= {7'h00, sw_pwrdn_r};
          `AMCS_REG_ACC_EXP:    rsp_r.rdata <= {4'h0, acc_exp_r};
          `AMCS_REG_VEL_EXP:    rsp_r.rdata <= {4'h0, vel_exp_r};
          `AMCS_REG_INTERP:     rsp_r.rdata <= {7'h00, interp_r};
          `AMCS_REG_DBL_STEP:   rsp_r.rdata <= {7'h00, dbl_step_r};
          `AMCS_REG_BLANK:      rsp_r.rdata <= {6'h00, blank_r};
          `AMCS_REG_CHOP_SEL:   rsp_r.rdata <= {7'h00, chop_r};
          `AMCS_REG_FD_CMP_OFF: rsp_r.rdata <= {7'h00, fd_cmp_off_r};
          `AMCS_REG_HEND_TFD:   rsp_r.rdata <= {4'h0, hend_r};
          `AMCS_REG_HSTRT_OFS:  rsp_r.rdata <= {4'h0, hstrt_r};
          default:              rsp_r.rdata <= 8'h00;
        endcase
      end else begin
        rsp_r.rdata <= 8'h00;
      end
    end
  end
  assign host_rsp = rsp_r;

  // switch-stop latch; cleared when a new motion command restarts the axis
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      switch_stopped_r <= 1'b0;
    end else if (end_switch_hit) begin
      switch_stopped_r <= 1'b1;
    end else if (motion_cmd != AMCS_CMD_NONE) begin
      switch_stopped_r <= 1'b0;
    end
  end

  assign stop_hard       = end_switch_hit && !soft_stop_r;
  assign stop_soft       = end_switch_hit && soft_stop_r;
  assign standby_current = switch_stopped_r && sw_pwrdn_r;

  always_comb begin
    ramp_cfg.ramp_mode       = ramp_mode_r;
    ramp_cfg.pos_tracking    = ramp_mode_r == AMCS_RAMP_POSITION;
    ramp_cfg.linear_decel    = ramp_mode_r != AMCS_RAMP_SOFT;
    ramp_cfg.exp_decel       = ramp_mode_r == AMCS_RAMP_SOFT;
    ramp_cfg.run_continuous  = ramp_mode_r == AMCS_RAMP_VELOCITY;
    ramp_cfg.acc_exp         = acc_exp_r;
    ramp_cfg.vel_exp         = vel_exp_r;
    ramp_cfg.sw_stop_soft    = soft_stop_r;
    ramp_cfg.sw_stop_standby = sw_pwrdn_r;
  end

  // interpolation only meaningful at 16 microsteps; elsewhere one sub-step
  logic       interp_act;
  logic [8:0] sub_base;
  assign interp_act = interp_r && ustep_r == `AMCS_USTEP_16;
  assign sub_base   = interp_act ? 9'h010 : 9'h001;

  always_comb begin
    drv_cfg.ustep_res      = ustep_r;
    drv_cfg.ustep_per_full = 9'h001 << ustep_r;
    drv_cfg.sub_steps      = dbl_step_r ? {sub_base[7:0], 1'b0} : sub_base;
    drv_cfg.blank_sel      = blank_r;
    drv_cfg.chop_mode      = chop_r;
    drv_cfg.fd_cmp_off     = (chop_r == AMCS_CHOP_CONST_OFF) && fd_cmp_off_r;
    drv_cfg.hyst_end       = (chop_r == AMCS_CHOP_HYSTERESIS) ? hend_r : 4'h0;
    drv_cfg.fd_time        = (chop_r == AMCS_CHOP_CONST_OFF) ? hend_r : 4'h0;
    drv_cfg.hyst_start     = (chop_r == AMCS_CHOP_HYSTERESIS) ? hstrt_r : 4'h0;
    drv_cfg.sine_offset    = (chop_r == AMCS_CHOP_CONST_OFF) ? hstrt_r : 4'h0;
  end

  // exponent, blank and chopper write checks compare against the value offered one cycle earlier
  a_cmd_sets_mode: assert property (@(posedge clk_sys) disable iff (sys_rst)
    motion_cmd == AMCS_CMD_MOVE_TO_TARGET |=> ramp_mode_r == AMCS_RAMP_POSITION)
    else $error("move command did not select position mode");
  a_rotate_velocity: assert property (@(posedge clk_sys) disable iff (sys_rst)
    motion_cmd inside {AMCS_CMD_ROTATE_RIGHT, AMCS_CMD_ROTATE_LEFT, AMCS_CMD_MOTOR_HALT}
    |=> ramp_cfg.run_continuous)
    else $error("rotate or halt did not select velocity mode");
  a_move_trapezoid: assert property (@(posedge clk_sys) disable iff (sys_rst)
    motion_cmd == AMCS_CMD_MOVE_TO_TARGET
    |=> ramp_cfg.pos_tracking && ramp_cfg.linear_decel && !ramp_cfg.run_continuous)
    else $error("position mode not tracking with linear ramps");
  a_soft_exp: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_ok && host_req.num == `AMCS_REG_RAMP_MODE && host_req.wdata == 8'h01 &&
    motion_cmd == AMCS_CMD_NONE |=> ramp_cfg.exp_decel && !ramp_cfg.linear_decel)
    else $error("soft mode deceleration shape wrong");
  a_ustep_range: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ustep_r <= `AMCS_MAX_USTEP)
    else $error("resolution out of range");
  a_ustep_decode: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_ok && host_req.num == `AMCS_REG_USTEP_RES && host_req.wdata == 8'h08
    |=> drv_cfg.ustep_per_full == 9'h100)
    else $error("finest resolution not decoded");
  a_exp_range: assert property (@(posedge clk_sys) disable iff (sys_rst)
    acc_exp_r <= `AMCS_MAX_EXP && vel_exp_r <= `AMCS_MAX_EXP)
    else $error("scale exponent out of range");
  a_acc_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_ok && host_req.num == `AMCS_REG_ACC_EXP
    |=> {4'h0, ramp_cfg.acc_exp} == $past(host_req.wdata))
    else $error("acceleration exponent not stored");
  a_vel_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_ok && host_req.num == `AMCS_REG_VEL_EXP
    |=> {4'h0, ramp_cfg.vel_exp} == $past(host_req.wdata))
    else $error("velocity exponent not stored");
  a_reject_keeps: assert property (@(posedge clk_sys) disable iff (sys_rst)
    host_req.wr && host_req.num == `AMCS_REG_VEL_EXP && host_req.wdata > {4'h0, `AMCS_MAX_EXP}
    |=> $stable(vel_exp_r) && host_rsp.err)
    else $error("out of range write altered setting");
  a_acc_reject: assert property (@(posedge clk_sys) disable iff (sys_rst)
    host_req.wr && host_req.num == `AMCS_REG_ACC_EXP && host_req.wdata > {4'h0, `AMCS_MAX_EXP}
    |=> $stable(acc_exp_r) && host_rsp.err)
    else $error("out of range acceleration write altered setting");
  a_mode_reject: assert property (@(posedge clk_sys) disable iff (sys_rst)
    host_req.wr && host_req.num == `AMCS_REG_RAMP_MODE &&
    host_req.wdata > {6'h00, `AMCS_MAX_RAMP_MODE} && motion_cmd == AMCS_CMD_NONE
    |=> $stable(ramp_mode_r) && host_rsp.err)
    else $error("refused mode write altered setting");
  a_ack_follows: assert property (@(posedge clk_sys) disable iff (sys_rst)
    host_req.wr || host_req.rd |=> host_rsp.ack)
    else $error("request not acknowledged");
  a_ack_single: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !host_req.wr && !host_req.rd |=> !host_rsp.ack && !host_rsp.err)
    else $error("answer without request");
  a_stop_kind: assert property (@(posedge clk_sys) disable iff (sys_rst)
    end_switch_hit |-> (stop_soft == soft_stop_r) && (stop_hard != soft_stop_r))
    else $error("switch stop type wrong");
  a_standby_cur: assert property (@(posedge clk_sys) disable iff (sys_rst)
    end_switch_hit && motion_cmd == AMCS_CMD_NONE ##1 motion_cmd == AMCS_CMD_NONE
    |-> standby_current == sw_pwrdn_r)
    else $error("stopped current selection wrong");
  a_standby_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !end_switch_hit && motion_cmd != AMCS_CMD_NONE |=> !standby_current)
    else $error("standby current kept after restart");
  a_interp_gain: assert property (@(posedge clk_sys) disable iff (sys_rst)
    interp_r && ustep_r == `AMCS_USTEP_16 && !dbl_step_r |-> drv_cfg.sub_steps == 9'h010)
    else $error("interpolation not applied");
  a_interp_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ustep_r != `AMCS_USTEP_16 && !dbl_step_r |-> drv_cfg.sub_steps == 9'h001)
    else $error("interpolation applied at wrong resolution");
  a_double_step: assert property (@(posedge clk_sys) disable iff (sys_rst)
    dbl_step_r && !interp_r |-> drv_cfg.sub_steps == 9'h002)
    else $error("double step not applied");
  a_blank_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_ok && host_req.num == `AMCS_REG_BLANK
    |=> {6'h00, drv_cfg.blank_sel} == $past(host_req.wdata))
    else $error("blank time not stored");
  a_chop_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_ok && host_req.num == `AMCS_REG_CHOP_SEL
    |=> {7'h00, drv_cfg.chop_mode} == $past(host_req.wdata))
    else $error("chopper mode not stored");
  a_fd_cmp_mode: assert property (@(posedge clk_sys) disable iff (sys_rst)
    drv_cfg.fd_cmp_off |-> chop_r == AMCS_CHOP_CONST_OFF)
    else $error("fast decay comparator disable outside constant-off");
  a_hyst_route: assert property (@(posedge clk_sys) disable iff (sys_rst)
    chop_r == AMCS_CHOP_HYSTERESIS
    |-> drv_cfg.hyst_end == hend_r && drv_cfg.fd_time == 4'h0)
    else $error("hysteresis end routed wrongly");
  a_hstrt_route: assert property (@(posedge clk_sys) disable iff (sys_rst)
    chop_r == AMCS_CHOP_CONST_OFF
    |-> drv_cfg.sine_offset == hstrt_r && drv_cfg.hyst_start == 4'h0)
    else $error("sine offset routed wrongly");

endmodule

// *** tb/amcs_host_model.sv ***
/*
  host-side model: issues parameter reads and writes by number.
  assumes: request taken on a rising clk_sys, answer one cycle later.
*/
module amcs_host_model (
  input  wire logic                clk_sys,
  output      amcs_pkg::amcs_req_t host_req,
  input  wire amcs_pkg::amcs_rsp_t host_rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  import amcs_pkg::*;

  initial host_req = '0;

  // callers sweep resolution codes 0..8 and acceleration exponents 1..13, and also offer refused values
  task automatic xfer(input logic wr, input logic [7:0] num, input logic [7:0] data,
                      output amcs_rsp_t rsp);
    @(posedge clk_sys);
    #1 host_req = '{wr: wr, rd: !wr, num: num, wdata: data};
    @(posedge clk_sys);
    #1 host_req = '0;
    rsp = host_rsp;
  endtask
endmodule

// *** tb/tb.sv ***
/*
  self-checking bench for the axis settings block.
  assumes: host model drives the parameter port; bench drives commands.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import amcs_pkg::*;

  typedef struct {
    logic [7:0] num;
    logic [7:0] val;
    logic       err;
    logic [7:0] rd;
  } amcs_row_t;

  logic           clk_sys = 1'b0;
  logic           sys_rst = 1'b1;
  amcs_req_t      host_req;
  amcs_rsp_t      host_rsp;
  amcs_rsp_t      rsp;
  amcs_cmd_t      motion_cmd = AMCS_CMD_NONE;
  logic           end_switch_hit = 1'b0;
  amcs_ramp_cfg_t ramp_cfg;
  amcs_drv_cfg_t  drv_cfg;
  logic           stop_hard;
  logic           stop_soft;
  logic           standby_current;
  int             bad_count = 0;
  int             checked = 0;

  // write value, refused flag, then value read back
  amcs_row_t rows [12] = '{
    '{8'h8a, 8'h01, 1'b0, 8'h01}, '{8'h8a, 8'h03, 1'b1, 8'h01},
    '{8'h8c, 8'h09, 1'b1, 8'h08}, '{8'h8c, 8'h03, 1'b0, 8'h03},
    '{8'ha6, 8'h08, 1'b0, 8'h08}, '{8'ha6, 8'h09, 1'b1, 8'h08},
    '{8'ha2, 8'h03, 1'b0, 8'h03}, '{8'ha2, 8'h04, 1'b1, 8'h03},
    '{8'ha5, 8'h0f, 1'b0, 8'h0f}, '{8'h95, 8'h02, 1'b1, 8'h00},
    '{8'ha3, 8'h01, 1'b0, 8'h01}, '{8'h10, 8'h01, 1'b1, 8'h00}};
  amcs_cmd_t  cmds  [6] = '{AMCS_CMD_MOVE_TO_TARGET, AMCS_CMD_ROTATE_RIGHT,
                            AMCS_CMD_MOVE_TO_TARGET, AMCS_CMD_ROTATE_LEFT,
                            AMCS_CMD_MOVE_TO_TARGET, AMCS_CMD_MOTOR_HALT};
  amcs_ramp_t modes [6] = '{AMCS_RAMP_POSITION, AMCS_RAMP_VELOCITY, AMCS_RAMP_POSITION,
                            AMCS_RAMP_VELOCITY, AMCS_RAMP_POSITION, AMCS_RAMP_VELOCITY};

  always #5 clk_sys = ~clk_sys;

  amcs_host_model u_host (
    .clk_sys  (clk_sys),
    .host_req (host_req),
    .host_rsp (host_rsp)
  );

  amcs_settings u_dut (
    .clk_sys         (clk_sys),
    .sys_rst         (sys_rst),
    .host_req        (host_req),
    .host_rsp        (host_rsp),
    .motion_cmd      (motion_cmd),
    .end_switch_hit  (end_switch_hit),
    .ramp_cfg        (ramp_cfg),
    .drv_cfg         (drv_cfg),
    .stop_hard       (stop_hard),
    .stop_soft       (stop_soft),
    .standby_current (standby_current)
  );

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] n, input logic [7:0] d);
    u_host.xfer(1'b1, n, d, rsp);
    chk("write ack", 16'h0001, 16'(rsp.ack));
  endtask

  task automatic rd(input logic [7:0] n);
    u_host.xfer(1'b0, n, 8'h00, rsp);
    chk("read ack", 16'h0001, 16'(rsp.ack));
  endtask

  task automatic step_cmd(input amcs_cmd_t c);
    @(posedge clk_sys);
    #1 motion_cmd = c;
    @(posedge clk_sys);
    #1 motion_cmd = AMCS_CMD_NONE;
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // bounds the whole run; every other wait is a fixed count
  initial begin
    #500us;
    bad_count++;
    close_out();
  end

  initial begin
    repeat (10) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    rd(8'h8c);
    chk("reset resolution", 16'(8'h08), 16'(rsp.rdata));
    chk("reset mode", 16'(AMCS_RAMP_POSITION), 16'(ramp_cfg.ramp_mode));
    foreach (rows[i]) begin
      wr(rows[i].num, rows[i].val);
      chk("write err", 16'(rows[i].err), 16'(rsp.err));
      rd(rows[i].num);
      chk("read back", 16'(rows[i].rd), 16'(rsp.rdata));
    end
    chk("exp decel", 16'(1'b1), 16'(ramp_cfg.exp_decel));
    chk("linear decel", 16'(1'b0), 16'(ramp_cfg.linear_decel));
    foreach (cmds[i]) begin
      step_cmd(cmds[i]);
      chk("ramp mode", 16'(modes[i]), 16'(ramp_cfg.ramp_mode));
      chk("tracking", 16'(modes[i] == AMCS_RAMP_POSITION), 16'(ramp_cfg.pos_tracking));
      chk("continuous", 16'(modes[i] == AMCS_RAMP_VELOCITY), 16'(ramp_cfg.run_continuous));
    end
    for (int r = 0; r <= 8; r++) begin
      wr(8'h8c, 8'(r));
      chk("ustep per full", 16'(9'h001 << r), 16'(drv_cfg.ustep_per_full));
      chk("ustep code", 16'(r), 16'(drv_cfg.ustep_res));
    end
    wr(8'h8c, 8'h04);
    wr(8'ha0, 8'h01);
    chk("interp", 16'(9'h010), 16'(drv_cfg.sub_steps));
    wr(8'ha1, 8'h01);
    chk("double", 16'(9'h020), 16'(drv_cfg.sub_steps));
    wr(8'h8c, 8'h05);
    chk("no interp", 16'(9'h002), 16'(drv_cfg.sub_steps));
    wr(8'ha0, 8'h00);
    chk("double only", 16'(9'h002), 16'(drv_cfg.sub_steps));
    wr(8'ha4, 8'h01);
    chk("blank", 16'(2'h3), 16'(drv_cfg.blank_sel));
    chk("decay time", 16'(4'hf), 16'(drv_cfg.fd_time));
    chk("sine offset", 16'(4'h8), 16'(drv_cfg.sine_offset));
    chk("cmp off", 16'(1'b1), 16'(drv_cfg.fd_cmp_off));
    wr(8'ha3, 8'h00);
    chk("chop mode", 16'(AMCS_CHOP_HYSTERESIS), 16'(drv_cfg.chop_mode));
    chk("hyst end", 16'(4'hf), 16'(drv_cfg.hyst_end));
    chk("hyst start", 16'(4'h8), 16'(drv_cfg.hyst_start));
    chk("cmp off hyst", 16'(1'b0), 16'(drv_cfg.fd_cmp_off));
    chk("no decay time", 16'(4'h0), 16'(drv_cfg.fd_time));
    for (int e = 1; e <= 13; e++) begin
      wr(8'h99, 8'(e));
      chk("acc exp", 16'(e), 16'(ramp_cfg.acc_exp));
    end
    wr(8'h99, 8'h0e);
    chk("acc exp kept", 16'(4'hd), 16'(ramp_cfg.acc_exp));
    wr(8'h9a, 8'h01);
    chk("vel exp", 16'(4'h1), 16'(ramp_cfg.vel_exp));
    wr(8'h9a, 8'h0e);
    chk("vel err", 16'(1'b1), 16'(rsp.err));
    chk("vel exp kept", 16'(4'h1), 16'(ramp_cfg.vel_exp));
    wr(8'h96, 8'h01);
    @(posedge clk_sys);
    #1 end_switch_hit = 1'b1;
    @(negedge clk_sys);
    chk("hard stop", 16'(2'b10), 16'({stop_hard, stop_soft}));
    @(posedge clk_sys);
    #1 end_switch_hit = 1'b0;
    chk("standby", 16'(1'b1), 16'(standby_current));
    chk("standby flag", 16'(1'b1), 16'(ramp_cfg.sw_stop_standby));
    wr(8'h95, 8'h01);
    @(posedge clk_sys);
    #1 end_switch_hit = 1'b1;
    @(negedge clk_sys);
    chk("soft stop", 16'(2'b01), 16'({stop_hard, stop_soft}));
    chk("soft flag", 16'(1'b1), 16'(ramp_cfg.sw_stop_soft));
    @(posedge clk_sys);
    #1 end_switch_hit = 1'b0;
    step_cmd(AMCS_CMD_ROTATE_RIGHT);
    chk("run current", 16'(standby_current), 16'(1'b0));
    // second reset in mid-run must restore defaults
    @(posedge clk_sys);
    #1 sys_rst = 1'b1;
    @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    rd(8'h99);
    chk("reset exp", 16'(8'h00), 16'(rsp.rdata));
    chk("reset mode 2", 16'(AMCS_RAMP_POSITION), 16'(ramp_cfg.ramp_mode));
    close_out();
  end
endmodule
